// >>> hw/adcsp_defs.svh
// constants for the converter serial port configuration block
`ifndef ADCSP_DEFS_SVH
`define ADCSP_DEFS_SVH

// interface mode pins value that selects the serial port
`define ADCSP_MODE_SERIAL   2'h3
// result width and bit count of one read
`define ADCSP_RES_W         18
`define ADCSP_RES_BITS      6'd18
`define ADCSP_LAST_BIT      6'd17
`define ADCSP_CNT_MAX       6'h3f

// register offsets on the plain register port
`define ADCSP_OFF_STATUS    4'h0
`define ADCSP_OFF_MASK      4'h4
`define ADCSP_OFF_CFG       4'h8
`define ADCSP_OFF_STRAP     4'hc

// status and mask bit positions and mask reset value
`define ADCSP_EV_DONE       0
`define ADCSP_EV_RDERR      1
`define ADCSP_MASK_RST      2'h0

// timing: core clock period and internal serial clock half period
`define ADCSP_CLK_NS        10
`define ADCSP_SCLK_HALF_NS  40
`define ADCSP_SCLK_HALF_CYC ((`ADCSP_SCLK_HALF_NS + `ADCSP_CLK_NS - 1) / `ADCSP_CLK_NS)

`endif

// >>> hw/adcsp_pkg.sv
// types shared by the converter serial port configuration block
package adcsp_pkg;
`include "adcsp_defs.svh"

    // read sequencer states
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_SHIFT
    } adcsp_state_t;

    // output shift register state
    typedef struct packed {
        logic [`ADCSP_RES_W-1:0] data;
    } adcsp_sr_t;

    // two stage synchroniser state
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
    } adcsp_sync_t;

    // whole state of the top module
    typedef struct packed {
        adcsp_state_t            st;
        logic [7:0]              div_cnt;
        logic [5:0]              bit_cnt;
        logic                    sclk_int;
        logic                    sclk_prev;
        logic                    busy_d;
        logic [`ADCSP_RES_W-1:0] hold;
        logic                    hold_ok;
        logic [1:0]              status;
        logic [1:0]              mask;
        logic [7:0]              cfg_div;
        logic [7:0]              rdata;
        logic [3:0]              par_o;
        logic [3:0]              par_oe;
        logic                    sclk_o;
        logic                    sclk_oe;
        logic                    serial_result_out;
        logic                    fsync;
        logic                    rderr;
        logic                    irq;
    } adcsp_top_t;
endpackage : adcsp_pkg

// >>> hw/adcsp_sync.sv
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module adcsp_sync
    import adcsp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] d,
    output logic      [7:0] q
);
    adcsp_sync_t r_reg;  // both stages
    adcsp_sync_t r_next; // next value

    // first stage feeds only the second stage
    always_comb begin
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
    end

    // register both stages
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.s2;
endmodule : adcsp_sync

// >>> hw/adcsp_shreg.sv
// result shift register, msb out, chain data in at the bottom
`timescale 1ns/1ps
module adcsp_shreg
    import adcsp_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    input  wire logic                    load,
    input  wire logic [`ADCSP_RES_W-1:0] load_val,
    input  wire logic                    shift,
    input  wire logic                    ser_in,
    output logic                         q
);
    adcsp_sr_t r_reg;  // shift register
    adcsp_sr_t r_next; // next value

    // load wins over shift; chain data enters at bit zero
    always_comb begin
        r_next = r_reg;
        if (load) begin
            r_next.data = load_val;
        end else if (shift) begin
            r_next.data = {r_reg.data[`ADCSP_RES_W-2:0], ser_in};
        end
    end

    // register the state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.data[`ADCSP_RES_W-1];
endmodule : adcsp_shreg

// >>> hw/adcsp_top.sv
// serial result port configuration and shared pin control of the converter
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
module adcsp_top
    import adcsp_pkg::*;
(
    input  wire logic                    CORE_CLK,
    input  wire logic                    ARST_N,
    input  wire logic [1:0]              MODE,
    input  wire logic                    READ_EN_N,
    input  wire logic [`ADCSP_RES_W-1:0] RESULT,
    input  wire logic                    CONV_DONE,
    input  wire logic                    CONV_BUSY,
    input  wire logic [3:0]              PAR_BIT_IN,
    output logic      [3:0]              PAR_BIT_O,
    output logic      [3:0]              PAR_BIT_OE,
    input  wire logic                    SCLK_IN,
    output logic                         SCLK_O,
    output logic                         SCLK_OE,
    output logic                         SER_RESULT_OUT,
    output logic                         FRAME_SYNC,
    output logic                         INCOMPLETE_READ_FLAG,
    output logic                         IRQ,
    input  wire logic [3:0]              REG_ADDR,
    input  wire logic [7:0]              REG_WDATA,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    output logic      [7:0]              REG_RDATA
);
    adcsp_top_t r_reg;       // whole block state
    adcsp_top_t r_next;      // next state
    logic [7:0] pins_s;      // synchronised pins
    logic [1:0] mode_s;      // interface mode
    logic       clk_src_s;   // clock_source_select, high = host clock
    logic       fs_pol_s;    // frame_sync_polarity_select
    logic       sclk_inv_s;  // serial_clock_invert
    logic       rdc_chain_s; // readmode_or_chain_input
    logic       sclk_s;      // host serial clock level
    logic       rd_n_s;      // read enable, active low
    logic       serial;      // serial mode selected
    logic       ext_mode;    // host supplies the clock
    logic       upd_edge;    // external update edge seen
    logic       busy_rise;   // conversion just started
    logic       sr_load;     // load shift register
    logic       sr_shift;    // shift one bit
    logic       sr_q;        // shift register msb
    logic       abort;       // unfinished read dropped
    logic       done_ev;     // all result bits sent
    logic [1:0] clr;         // write-one-to-clear bits
    logic [1:0] ev;          // status events this cycle

    // mode, shared, clock and read enable pins go through two flops before use; result, done and busy do not
    adcsp_sync u_sync (
        .clk    (CORE_CLK),
        .arst_n (ARST_N),
        .d      ({MODE, PAR_BIT_IN, SCLK_IN, READ_EN_N}),
        .q      (pins_s)
    );

    assign mode_s      = pins_s[7:6];
    assign clk_src_s   = pins_s[2];
    assign fs_pol_s    = pins_s[3];
    assign sclk_inv_s  = pins_s[4];
    assign rdc_chain_s = pins_s[5];
    assign sclk_s      = pins_s[1];
    assign rd_n_s      = pins_s[0];
    assign serial      = (mode_s == `ADCSP_MODE_SERIAL);
    assign ext_mode    = clk_src_s;
    assign busy_rise   = CONV_BUSY & ~r_reg.busy_d;

    // host clock edge with inversion applied; rising edge updates the data
    assign upd_edge = (sclk_s ^ sclk_inv_s) & ~(r_reg.sclk_prev ^ sclk_inv_s);

    // result shifts out msb first; chain data fills from the bottom
    adcsp_shreg u_shreg (
        .clk      (CORE_CLK),
        .arst_n   (ARST_N),
        .load     (sr_load),
        .load_val (r_reg.hold),
        .shift    (sr_shift),
        .ser_in   (ext_mode & rdc_chain_s),
        .q        (sr_q)
    );

    // next state of the whole block
    always_comb begin
        r_next    = r_reg;
        sr_load   = 1'b0;
        sr_shift  = 1'b0;
        abort     = 1'b0;
        done_ev   = 1'b0;
        clr       = 2'h0;
        ev        = 2'h0;
        r_next.sclk_prev = sclk_s;
        r_next.busy_d    = CONV_BUSY;
        // a finished conversion always refreshes the held result
        if (CONV_DONE) begin
            r_next.hold    = RESULT;
            r_next.hold_ok = 1'b1;
        end
        unique case (r_reg.st)
            ST_IDLE: begin
                r_next.sclk_int = 1'b0;
                r_next.div_cnt  = 8'h00;
                if (serial && !rd_n_s && r_reg.hold_ok) begin
                    // internal clock: readmode picks during or after conversion
                    if (ext_mode || (rdc_chain_s ? busy_rise : !CONV_BUSY)) begin
                        sr_load          = 1'b1;
                        r_next.st        = ST_SHIFT;
                        r_next.bit_cnt   = 6'h00;
                        r_next.hold_ok   = CONV_DONE;
                    end
                end
            end
            ST_SHIFT: begin
                if (!serial || rd_n_s) begin
                    // host let go of the read; stop quietly
                    r_next.st = ST_IDLE;
                end else if (ext_mode) begin
                    if (CONV_DONE && r_reg.bit_cnt < `ADCSP_RES_BITS) begin
                        // new result overruns an unfinished read: drop it
                        abort        = 1'b1;
                        r_next.st    = ST_IDLE;
                    end else if (upd_edge) begin
                        sr_shift = 1'b1;
                        // count saturates so long chains keep shifting
                        if (r_reg.bit_cnt != `ADCSP_CNT_MAX) begin
                            r_next.bit_cnt = r_reg.bit_cnt + 6'h01;
                        end
                        done_ev = (r_reg.bit_cnt == `ADCSP_LAST_BIT);
                    end
                end else begin
                    // internal clock divider; cfg of zero acts as one
                    if ((r_reg.div_cnt + 8'h01) >= r_reg.cfg_div) begin
                        r_next.div_cnt  = 8'h00;
                        r_next.sclk_int = ~r_reg.sclk_int;
                        // falling edge of the clock moves to the next bit
                        if (r_reg.sclk_int) begin
                            sr_shift       = 1'b1;
                            r_next.bit_cnt = r_reg.bit_cnt + 6'h01;
                            if (r_reg.bit_cnt == `ADCSP_LAST_BIT) begin
                                done_ev   = 1'b1;
                                r_next.st = ST_IDLE;
                            end
                        end
                    end else begin
                        r_next.div_cnt = r_reg.div_cnt + 8'h01;
                    end
                end
            end
        endcase

        // register writes; status is write-one-to-clear, set wins
        if (REG_WR) begin
            unique case (REG_ADDR)
                `ADCSP_OFF_STATUS: clr = REG_WDATA[1:0];
                `ADCSP_OFF_MASK:   r_next.mask = REG_WDATA[1:0];
                `ADCSP_OFF_CFG:    r_next.cfg_div = REG_WDATA;
                default: ;
            endcase
        end
        ev[`ADCSP_EV_DONE]  = done_ev;
        ev[`ADCSP_EV_RDERR] = abort;
        r_next.status = (r_reg.status & ~clr) | ev;
        r_next.irq    = |(r_next.status & r_next.mask);

        // read data stand only in the cycle after the strobe
        r_next.rdata = 8'h00;
        if (REG_RD) begin
            unique case (REG_ADDR)
                `ADCSP_OFF_STATUS: r_next.rdata = {6'h00, r_reg.status};
                `ADCSP_OFF_MASK:   r_next.rdata = {6'h00, r_reg.mask};
                `ADCSP_OFF_CFG:    r_next.rdata = r_reg.cfg_div;
                `ADCSP_OFF_STRAP:  r_next.rdata = {CONV_BUSY, r_reg.st == ST_SHIFT,
                                                  serial, rdc_chain_s, sclk_inv_s,
                                                  fs_pol_s, clk_src_s, r_reg.hold_ok};
                default:           r_next.rdata = 8'h00;
            endcase
        end

        // pin drive: serial port functions or parallel result bits
        r_next.rderr = abort;
        if (serial) begin
            r_next.par_oe  = 4'h0;
            r_next.par_o   = 4'h0;
            r_next.sclk_oe = ~ext_mode;
            r_next.sclk_o  = r_reg.sclk_int ^ sclk_inv_s;
            r_next.serial_result_out   = sr_q;
            // sync only frames internal clock reads; idle level otherwise
            r_next.fsync   = (!ext_mode && r_reg.st == ST_SHIFT) ^ fs_pol_s;
        end else begin
            r_next.par_oe  = 4'hf;
            r_next.par_o   = r_reg.hold[9:6];
            r_next.sclk_oe = 1'b1;
            r_next.sclk_o  = r_reg.hold[11];
            r_next.serial_result_out   = r_reg.hold[10];
            r_next.fsync   = r_reg.hold[12];
            r_next.rderr   = r_reg.hold[13];
        end
    end

    // single state register, constant reset values only
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r_reg         <= '0;
            r_reg.st      <= ST_IDLE;
            r_reg.mask    <= `ADCSP_MASK_RST;
            r_reg.cfg_div <= 8'(`ADCSP_SCLK_HALF_CYC);
        end else begin
            r_reg <= r_next;
        end
    end

    // every output straight from the state register
    assign PAR_BIT_O            = r_reg.par_o;
    assign PAR_BIT_OE           = r_reg.par_oe;
    assign SCLK_O               = r_reg.sclk_o;
    assign SCLK_OE              = r_reg.sclk_oe;
    assign SER_RESULT_OUT       = r_reg.serial_result_out;
    assign FRAME_SYNC           = r_reg.fsync;
    assign INCOMPLETE_READ_FLAG = r_reg.rderr;
    assign IRQ                  = r_reg.irq;
    assign REG_RDATA            = r_reg.rdata;

    // checks on the design's own behaviour
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);

    sequence read_start_s;
        sr_load ##1 (r_reg.st == ST_SHIFT);
    endsequence

    sequence abort_pulse_s;
        INCOMPLETE_READ_FLAG ##1 !INCOMPLETE_READ_FLAG;
    endsequence

    chk_parallel_drive: assert property (
        !serial |=> (PAR_BIT_OE == 4'hf && PAR_BIT_O == $past(r_reg.hold[9:6])))
        else $error("shared pins not driven as parallel bits");

    chk_int_clock_out: assert property (
        (serial && !ext_mode) |=> SCLK_OE)
        else $error("internal clock not driven out");

    chk_ext_clock_in: assert property (
        (serial && ext_mode) |=> !SCLK_OE)
        else $error("clock pin driven while host clocks");

    chk_sync_polarity: assert property (
        (serial && !ext_mode && r_reg.st == ST_SHIFT) |=> (FRAME_SYNC == !$past(fs_pol_s)))
        else $error("frame sync level wrong during read");

    chk_clock_invert: assert property (
        (serial && !ext_mode && r_reg.st == ST_IDLE && !r_reg.sclk_int)
            |=> (SCLK_O == $past(sclk_inv_s)))
        else $error("idle internal clock ignores inversion");

    chk_msb_first: assert property (
        (serial && sr_load) |-> read_start_s ##1 (SER_RESULT_OUT == $past(r_reg.hold[17], 2)))
        else $error("first bit out is not the msb");

    chk_rderr_pulse: assert property (
        abort |=> abort_pulse_s)
        else $error("read error not a single pulse");

    chk_read_mode_start: assert property (
        (sr_load && !ext_mode) |-> (rdc_chain_s ? busy_rise : !CONV_BUSY))
        else $error("internal read started at wrong time");

    chk_ext_update_edge: assert property (
        (sr_shift && ext_mode && serial) |-> upd_edge)
        else $error("shift without external update edge");
endmodule : adcsp_top

// >>> test/adcsp_host.sv
// behavioural host serial controller that reads results from the port
`timescale 1ns/1ps
module adcsp_host (
    input  wire logic        clk,
    input  wire logic        go,      // start one read
    input  wire logic [5:0]  n,       // bits to clock with the host clock
    input  wire logic        ext,     // host sources the serial clock
    input  wire logic        inv,     // clock invert strap
    input  wire logic        pol,     // frame sync polarity strap
    input  wire logic        sdo,
    input  wire logic        fs,
    input  wire logic        sck_dev, // clock pin as the port drives it
    output logic             rd_n,
    output logic             sck,
    output logic             busy,
    output logic             vld,     // one pulse when a read is over
    output logic [5:0]       cnt,
    output logic [35:0]      bits
);
    logic prev;
    logic infr;

    // idle state; the host clock stands still outside frames
    initial begin
        rd_n = 1'b1;
        sck = 1'b1;
        busy = 1'b0;
        vld = 1'b0;
    end

    // idle level follows the strap only between reads
    always @(inv) if (!busy) sck = ~inv;

    // one read per go, in either clock mode
    task automatic run();
        busy = 1'b1;
        bits = '0;
        cnt = '0;
        infr = 1'b0;
        prev = 1'b0;
        rd_n <= 1'b0;
        if (ext) begin
            #200;
            repeat (n) begin
                sck = inv;
                bits = {bits[34:0], sdo};
                cnt++;
                #62.5;
                sck = ~inv;                // update edge, data moves after it
                #62.5;
            end
            @(posedge clk);
        end else begin
            // sample at the edge opposite to where the port changes data
            repeat (3000) begin
                @(posedge clk);
                if (fs != pol) begin
                    infr = 1'b1;
                    if ((sck_dev ^ inv) && !prev) begin
                        bits = {bits[34:0], sdo};
                        cnt++;
                    end
                end else if (infr) break;
                prev = sck_dev ^ inv;
            end
        end
        rd_n <= 1'b1;
        vld = 1'b1;
        @(posedge clk);
        vld = 1'b0;
        busy = 1'b0;
    endtask : run

    // wait for a start request
    initial forever begin
        @(posedge clk);
        if (go) run();
    end
endmodule : adcsp_host

// >>> test/tb.sv
// self-checking bench for the serial port configuration block
`timescale 1ns/1ps
module tb;
    import adcsp_pkg::*;
    logic        clk, arst_n, done, cbusy, h_go, h_rd_n, h_sck, h_busy, h_vld;
    logic        sclk_o, sclk_oe, sdo, fs, flag, irq, reg_wr, reg_rd, rd_seen;
    logic [1:0]  mode;
    logic [17:0] res;
    logic [3:0]  strap, par_o, par_oe, par_in, reg_addr;   // strap: board levels on pins
    logic [7:0]  reg_wdata, reg_rdata;
    logic [5:0]  h_n, h_cnt;
    logic [35:0] h_bits;
    logic [15:0] e;
    logic [41:0] sq[$];     // expected serial words {count, bits}
    logic [15:0] rq[$];     // expected reads {mask, value}
    int          fail_count, checked;

    // pins resolve to whoever drives them
    assign par_in = (par_oe & par_o) | (~par_oe & strap);

    adcsp_top u_dut (.CORE_CLK(clk), .ARST_N(arst_n), .MODE(mode), .READ_EN_N(h_rd_n),
        .RESULT(res), .CONV_DONE(done), .CONV_BUSY(cbusy), .PAR_BIT_IN(par_in),
        .PAR_BIT_O(par_o), .PAR_BIT_OE(par_oe), .SCLK_IN(sclk_oe ? sclk_o : h_sck),
        .SCLK_O(sclk_o), .SCLK_OE(sclk_oe), .SER_RESULT_OUT(sdo), .FRAME_SYNC(fs),
        .INCOMPLETE_READ_FLAG(flag), .IRQ(irq), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));

    adcsp_host u_host (.clk(clk), .go(h_go), .n(h_n), .ext(strap[0]), .inv(strap[2]),
        .pol(strap[1]), .sdo(sdo), .fs(fs), .sck_dev(sclk_o), .rd_n(h_rd_n), .sck(h_sck),
        .busy(h_busy), .vld(h_vld), .cnt(h_cnt), .bits(h_bits));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic cmp(input logic [41:0] got, input logic [41:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // one idle edge so a following call never re-raises the strobe in this step
        @(posedge clk);
    endtask : wr

    // the read data is checked by the monitor in the following cycle
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
        rq.push_back({m, x});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        // one idle edge so a following call never re-raises the strobe in this step
        @(posedge clk);
    endtask : rd

    task automatic new_result();
        res <= 18'($urandom());
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
    endtask : new_result

    task automatic host_read(input logic [5:0] n);
        h_n <= n;
        h_go <= 1'b1;
        @(posedge clk);
        h_go <= 1'b0;
    endtask : host_read

    // bounded wait for the host to finish; running out ends the run
    task automatic wait_host();
        int i;
        for (i = 0; i < 6000; i++) begin
            @(posedge clk);
            if (!h_busy) break;
        end
        if (i == 6000) begin
            fail_count++;
            $display("[ERR] %0t host read hung", $time);
            give_verdict();
        end
    endtask : wait_host

    // register read monitor: data stands only in the cycle after the strobe
    always @(posedge clk) rd_seen <= reg_rd;
    always @(negedge clk) if (rd_seen && rq.size() > 0) begin
        e = rq.pop_front();
        cmp(reg_rdata & e[15:8], e[7:0], "reg read");
    end

    // serial monitor: each finished host read against the oldest note
    always @(posedge h_vld) if (sq.size() > 0) cmp({h_cnt, h_bits}, sq.pop_front(), "word");

    initial begin
        {arst_n, done, cbusy, h_go, reg_wr, reg_rd, mode, strap, reg_addr} = '0;
        {res, reg_wdata, h_n} = '0;
        void'($urandom(32'ha0e8ed24));
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        // reset values, an unmapped place, mask write back
        rd(4'h4, 8'hff, 8'h00);
        rd(4'h8, 8'hff, 8'h04);
        rd(4'h0, 8'hff, 8'h00);
        rd(4'h2, 8'hff, 8'h00);
        wr(4'h4, 8'h03);
        rd(4'h4, 8'hff, 8'h03);
        // parallel mode: shared pins carry result bits six to nine
        new_result();
        repeat (5) @(posedge clk);
        cmp({par_oe, par_o}, {4'hf, res[9:6]}, "parallel bits");
        mode <= 2'h3;
        // internal clock: every read mode, polarity and inversion
        for (int k = 0; k < 8; k++) begin
            wr(4'h8, 8'(2 + $urandom_range(3)));
            wr(4'h4, {7'h0, k[0]});
            strap <= {k[0], k[2], k[1], 1'b0};
            cbusy <= ~k[0];
            repeat (6) @(posedge clk);
            new_result();
            sq.push_back({6'd18, 18'h0, res});
            host_read(6'd18);
            repeat (30) begin
                @(posedge clk);
                cmp(fs, strap[1], "early frame");
            end
            cmp(sclk_oe, 1'b1, "clock drive");
            cbusy <= k[0];
            wait_host();
            repeat (2) @(posedge clk);
            cmp(irq, k[0], "irq level");
            rd(4'h0, 8'h01, 8'h01);
            wr(4'h0, 8'h01);
            rd(4'h0, 8'h01, 8'h00);
        end
        // host clock: chain level follows the result after eighteen periods
        for (int k = 0; k < 4; k++) begin
            strap <= {k[0], k[1], 1'b0, 1'b1};
            cbusy <= 1'b0;
            repeat (6) @(posedge clk);
            wr(4'hc, 8'hff);
            rd(4'hc, 8'h3e, {2'h0, 1'b1, strap, 1'b0});
            new_result();
            sq.push_back({6'd36, res, {18{k[0]}}});
            host_read(6'd36);
            cmp(sclk_oe, 1'b0, "clock released");
            wait_host();
        end
        // a conversion ends in mid-read: data dropped, flag pulses
        wr(4'h4, 8'h02);
        new_result();
        host_read(6'd36);
        repeat (100) @(posedge clk);
        new_result();
        for (int i = 0; i < 30; i++) begin
            @(posedge clk);
            if (flag === 1'b1) break;
        end
        cmp(flag, 1'b1, "abort flag");
        @(posedge clk);
        cmp(flag, 1'b0, "abort pulse");
        wait_host();
        cmp(irq, 1'b1, "abort irq");
        rd(4'h0, 8'h02, 8'h02);
        wr(4'h0, 8'h02);
        repeat (3) @(posedge clk);
        cmp(irq, 1'b0, "irq cleared");
        give_verdict();
    end
endmodule : tb
